// file: common/fcsq_pkg.sv
// Package: register map, command codes, field layouts for the flash command sequencer
package fcsq_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CLKDIV = 8'h00;
  localparam logic [7:0] OFF_PARIDX = 8'h04;
  localparam logic [7:0] OFF_PARAM = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_PROT = 8'h10;
  localparam logic [7:0] OFF_ECC_ADDR = 8'h14;
  localparam logic [7:0] OFF_ECC_DATA = 8'h18;
  localparam logic [7:0] OFF_MARGIN = 8'h1c;
  localparam logic [7:0] OFF_MODE = 8'h20;
  // Command codes
  localparam logic [7:0] CMD_EV_ALL = 8'h01;
  localparam logic [7:0] CMD_EV_BLOCK = 8'h02;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_UNSECURE = 8'h0b;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0d;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
  localparam logic [7:0] CMD_EV_SECTION = 8'h10;
  localparam logic [7:0] CMD_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
  // Status bits
  localparam int ST_COMMAND_COMPLETE_FLAG = 7;
  localparam int ST_ACCESS_ERROR_FLAG = 5;
  localparam int ST_PROTECTION_VIOLATION_FLAG = 4;
  localparam int ST_MG_HI = 1;
  localparam int ST_MG_LO = 0;
  // Protection bits
  localparam int PR_PLDIS = 0;
  localparam int PR_PHDIS = 1;
  localparam int PR_POPEN = 2;
  localparam int PR_DOPEN = 3;
  // Ecc status bits in status word
  localparam int ST_SFD = 9;
  localparam int ST_DFD = 8;
  localparam logic [2:0] IDX_ZERO = 3'h0;
  localparam logic [6:0] DATA_BLOCK_ID = 7'h10;
  localparam logic [6:0] PGM_BLOCK_ID = 7'h7f;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [7:0] ALG_CYCLES = 8'h10;
  typedef enum logic [1:0] {FCSQ_IDLE, FCSQ_RUN} fcsq_state_t;
  typedef struct packed {
    logic [15:0] word0;
    logic [15:0] word1;
  } fcsq_params_t;
  typedef struct packed {
    fcsq_state_t st;
    logic [7:0] cnt;
    logic [7:0] cmd;
    logic [7:0] clkdiv;
    logic div_set;
    logic [2:0] idx;
    logic [5:0][15:0] param;
    logic command_complete_flag;
    logic access_error_flag;
    logic protection_violation_flag;
    logic mg_hi;
    logic mg_lo;
    logic sfd;
    logic dfd;
    logic [3:0] prot;
    logic special;
    logic [1:0] umargin;
    logic [1:0] fmargin;
    logic [22:0] ecc_addr;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic rd_invalid;
    logic busy;
  } fcsq_regs_t;
endpackage

// file: src/fcsq_top.sv
// Flash command sequencer for the data-flash block, with AHB-Lite register slave
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: Code 01 verifies all blocks erased
// R2: Code 02 verifies data-flash block erased
// R3: Block erase needs data open bit
// R4: Erase all needs all open bits
// R5: Code 0B erases all then verifies
// R6: Code 0D sets user margin level
// R7: Code 0E field margin, special only
// R8: Code 10 verifies word count erased
// R9: Code 11 programs, 12 erases sector
// R10: Program/erase before divider set errors
// R11: Invalid command code sets access error
// R12: Access error blocks command execution
// R13: Read during algorithm returns invalid data
// R14: Invalid read sets faults, captures address
// R15: Captured data and parity are zero
// R16: Software clears error flags before commands
// R17: Verify-all checks whole flash space
// R18: Completion flag rises after operation ends
// R19: Verify commands need index 000; only codes 01 and 02 check it, code 10 runs with any index
// R20: Verify-block picks block from bits 22:16
// R21: Unknown block address sets access error
// R22: Verify errors set margin status bits
// R23: Verify commands leave violation flag alone
module fcsq_top
  import fcsq_pkg::*;
#(
  parameter int ALG_LEN = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic flash_rd,
  input wire logic [22:0] flash_rd_addr,
  input wire logic verify_err,
  input wire logic verify_uncorr,
  output logic busy,
  output logic [7:0] active_cmd,
  output logic [1:0] margin_level,
  output logic rd_invalid
);
  fcsq_regs_t q, d;

  // Does the upper global address name an existing block
  function automatic logic valid_block(input logic [6:0] ga);
    valid_block = (ga == DATA_BLOCK_ID) || (ga == PGM_BLOCK_ID);
  endfunction

  // Program or erase commands need the clock divider
  function automatic logic writes_array(input logic [7:0] c);
    writes_array = (c == CMD_ERASE_ALL) || (c == CMD_ERASE_BLOCK) || (c == CMD_UNSECURE)
      || (c == CMD_PROGRAM) || (c == CMD_ERASE_SECTOR);
  endfunction

  // Codes this sequencer accepts at launch
  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = writes_array(c) || (c == CMD_EV_ALL) || (c == CMD_EV_BLOCK)
      || (c == CMD_USER_MARGIN) || (c == CMD_FIELD_MARGIN) || (c == CMD_EV_SECTION);
  endfunction

  function automatic logic [31:0] status_word(input fcsq_regs_t r);
    status_word = '0;
    status_word[ST_COMMAND_COMPLETE_FLAG] = r.command_complete_flag;
    status_word[ST_ACCESS_ERROR_FLAG] = r.access_error_flag;
    status_word[ST_PROTECTION_VIOLATION_FLAG] = r.protection_violation_flag;
    status_word[ST_MG_HI] = r.mg_hi;
    status_word[ST_MG_LO] = r.mg_lo;
    status_word[ST_SFD] = r.sfd;
    status_word[ST_DFD] = r.dfd;
  endfunction

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic launch;
    logic err;
    logic [7:0] c;
    wr = 1'b0;
    rd = 1'b0;
    launch = 1'b0;
    err = 1'b0;
    c = q.param[0][15:8];
    d = q;
    d.hreadyout = 1'b1;
    d.rd_invalid = 1'b0;
    // Data phase of previous address phase
    if (q.ap_valid) begin
      wr = q.ap_write;
    end
    // Read data latched at the address phase so it stands at the data phase edge;
    // a write landing in the same cycle is not seen by that read
    rd = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
    if (wr) begin
      unique case (q.ap_addr)
        OFF_CLKDIV: begin
          d.clkdiv = hwdata[7:0];
          d.div_set = 1'b1;
        end
        OFF_PARIDX: d.idx = hwdata[2:0];
        OFF_PARAM: if (q.command_complete_flag && q.idx < 3'd6) d.param[q.idx] = hwdata[15:0];
        OFF_STATUS: begin
          // Write one clears; set by the launch below wins
          if (hwdata[ST_ACCESS_ERROR_FLAG]) d.access_error_flag = 1'b0;
          if (hwdata[ST_PROTECTION_VIOLATION_FLAG]) d.protection_violation_flag = 1'b0;
          if (hwdata[ST_SFD]) d.sfd = 1'b0;
          if (hwdata[ST_DFD]) d.dfd = 1'b0;
          // Launch ignored while old errors stand
          if (hwdata[ST_COMMAND_COMPLETE_FLAG] && q.command_complete_flag && !q.access_error_flag && !q.protection_violation_flag) launch = 1'b1; // [R16]
        end
        OFF_PROT: d.prot = hwdata[3:0];
        OFF_MODE: d.special = hwdata[0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (haddr[7:0])
        OFF_CLKDIV: d.hrdata = {24'h0, q.clkdiv};
        OFF_PARIDX: d.hrdata = {29'h0, q.idx};
        OFF_PARAM: d.hrdata = (q.idx < 3'd6) ? {16'h0, q.param[q.idx]} : '0;
        OFF_STATUS: d.hrdata = status_word(q);
        OFF_PROT: d.hrdata = {28'h0, q.prot};
        OFF_ECC_ADDR: d.hrdata = {9'h0, q.ecc_addr};
        OFF_ECC_DATA: d.hrdata = '0; // [R15]
        OFF_MARGIN: d.hrdata = {28'h0, q.fmargin, q.umargin};
        OFF_MODE: d.hrdata = {31'h0, q.special};
        default: d.hrdata = '0;
      endcase
    end
    // Command checks at launch
    if (launch) begin
      unique case (c)
        CMD_EV_ALL, CMD_EV_BLOCK: begin
          if (q.idx != IDX_ZERO) err = 1'b1; // [R19]
          if (c == CMD_EV_BLOCK && !valid_block(q.param[0][6:0])) err = 1'b1; // [R20] [R21]
        end
        CMD_ERASE_ALL: if (!(&q.prot)) d.protection_violation_flag = 1'b1; // [R4]
        CMD_ERASE_BLOCK: if (q.param[0][6:0] == DATA_BLOCK_ID && !q.prot[PR_DOPEN])
          d.protection_violation_flag = 1'b1; // [R3]
        CMD_PROGRAM, CMD_ERASE_SECTOR: ; // [R9]
        CMD_UNSECURE, CMD_EV_SECTION, CMD_USER_MARGIN: ; // [R5] [R8]
        CMD_FIELD_MARGIN: if (!q.special) err = 1'b1; // [R7]
        default: err = 1'b1; // [R11]
      endcase
      if (writes_array(c) && !q.div_set) err = 1'b1; // [R10]
      if (err) d.access_error_flag = 1'b1; // [R12]
      else if (!d.protection_violation_flag) begin
        d.cmd = c;
        d.command_complete_flag = 1'b0;
        d.cnt = ALG_LEN[7:0];
        d.st = FCSQ_RUN;
        d.mg_hi = 1'b0;
        d.mg_lo = 1'b0;
        if (c == CMD_USER_MARGIN) d.umargin = q.param[1][1:0]; // [R6]
        if (c == CMD_FIELD_MARGIN) d.fmargin = q.param[1][1:0]; // [R7]
      end
    end
    // Algorithm execution
    unique case (q.st)
      FCSQ_IDLE: ;
      FCSQ_RUN: begin
        // Verify read margins sampled from array [R1] [R2] [R8] [R17] [R5]
        if (q.cmd == CMD_EV_ALL || q.cmd == CMD_EV_BLOCK || q.cmd == CMD_EV_SECTION
            || q.cmd == CMD_UNSECURE) begin
          if (verify_err) d.mg_hi = 1'b1; // [R22]
          if (verify_uncorr) d.mg_lo = 1'b1; // [R22]
        end
        if (q.cnt == 8'h0) begin
          d.command_complete_flag = 1'b1; // [R18]
          d.st = FCSQ_IDLE;
        end else begin
          d.cnt = q.cnt - 8'h1;
        end
      end
      default: d.st = FCSQ_IDLE;
    endcase
    // Array read during algorithm
    if (flash_rd && !q.command_complete_flag) begin
      d.rd_invalid = 1'b1; // [R13]
      if (!q.sfd && !q.dfd) begin
        d.sfd = 1'b1; // [R14]
        d.dfd = 1'b1;
        d.ecc_addr = flash_rd_addr;
      end
    end
    // New address phase
    d.ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ);
    d.ap_write = hwrite;
    d.ap_addr = haddr[7:0];
    // Registered so the pin comes straight from a flop
    d.busy = !d.command_complete_flag;
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.command_complete_flag <= 1'b1;
      q.hreadyout <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign busy = q.busy;
  assign active_cmd = q.cmd;
  assign margin_level = q.umargin;
  assign rd_invalid = q.rd_invalid;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // -------------------------------------------------------------------
  // Launch checks
  // -------------------------------------------------------------------
  // Status write that the launch logic accepts this cycle
  logic chk_launch;
  assign chk_launch = q.ap_valid && q.ap_write && q.ap_addr == OFF_STATUS && clk_en
    && hwdata[ST_COMMAND_COMPLETE_FLAG] && q.command_complete_flag && !q.access_error_flag && !q.protection_violation_flag;

  bad_idx_err_a: assert property ((chk_launch && q.idx != IDX_ZERO // [R19]
    && q.param[0][15:8] == CMD_EV_ALL) |=> q.access_error_flag && q.command_complete_flag)
    else $error("verify launch with nonzero index not refused");

  no_div_err_a: assert property ((chk_launch && !q.div_set // [R10]
    && q.param[0][15:8] == CMD_PROGRAM) |=> q.access_error_flag)
    else $error("program without divider not refused");

  bad_code_a: assert property ((chk_launch // [R11]
    && !known_cmd(q.param[0][15:8])) |=> q.access_error_flag && q.command_complete_flag)
    else $error("unknown command code not refused");

  ev_blk_addr_a: assert property ((chk_launch && q.idx == IDX_ZERO // [R21]
    && q.param[0][15:8] == CMD_EV_BLOCK && !valid_block(q.param[0][6:0]))
    |=> q.access_error_flag && q.command_complete_flag)
    else $error("verify of unknown block not refused");

  ev_blk_run_a: assert property ((chk_launch && q.idx == IDX_ZERO // [R20]
    && q.param[0][15:8] == CMD_EV_BLOCK && valid_block(q.param[0][6:0]))
    |=> q.st == FCSQ_RUN && q.cmd == CMD_EV_BLOCK)
    else $error("verify of known block not started");

  field_mode_a: assert property ((chk_launch && !q.special // [R7]
    && q.param[0][15:8] == CMD_FIELD_MARGIN) |=> q.access_error_flag && q.command_complete_flag)
    else $error("field margin outside special mode not refused");

  erase_all_prot_a: assert property ((chk_launch && q.div_set && !(&q.prot) // [R4]
    && q.param[0][15:8] == CMD_ERASE_ALL) |=> q.protection_violation_flag && q.command_complete_flag)
    else $error("erase all without open bits not refused");

  erase_blk_prot_a: assert property ((chk_launch && q.div_set && !q.prot[PR_DOPEN] // [R3]
    && q.param[0][15:8] == CMD_ERASE_BLOCK && q.param[0][6:0] == DATA_BLOCK_ID)
    |=> q.protection_violation_flag && q.command_complete_flag)
    else $error("block erase without open bit not refused");

  ev_all_run_a: assert property ((chk_launch && q.idx == IDX_ZERO // [R17]
    && q.param[0][15:8] == CMD_EV_ALL) |=> q.st == FCSQ_RUN && q.cmd == CMD_EV_ALL)
    else $error("verify all not started");

  unsecure_run_a: assert property ((chk_launch && q.div_set // [R5]
    && q.param[0][15:8] == CMD_UNSECURE) |=> q.st == FCSQ_RUN && q.cmd == CMD_UNSECURE)
    else $error("unsecure not started");

  user_margin_a: assert property ((chk_launch // [R6]
    && q.param[0][15:8] == CMD_USER_MARGIN) |=> q.umargin == $past(q.param[1][1:0]))
    else $error("user margin level not taken");

  err_kept_a: assert property ((q.access_error_flag && q.command_complete_flag) |=> q.command_complete_flag) // [R12]
    else $error("command launched over access error");

  err_no_run_a: assert property ($rose(q.access_error_flag) |-> q.st == FCSQ_IDLE) // [R12]
    else $error("command ran despite access error");

  // -------------------------------------------------------------------
  // Algorithm checks
  // -------------------------------------------------------------------
  done_flag_a: assert property ((q.st == FCSQ_RUN && q.cnt == 8'h0 && clk_en) // [R18]
    |=> q.command_complete_flag && q.st == FCSQ_IDLE)
    else $error("completion flag not set at end");

  run_busy_a: assert property (q.st == FCSQ_RUN |-> !q.command_complete_flag) // [R18]
    else $error("completion flag high while running");

  run_len_a: assert property ($fell(q.command_complete_flag) |-> q.cnt == ALG_LEN[7:0]) // [R18]
    else $error("run length not loaded");

  launch_only_a: assert property ($fell(q.command_complete_flag) |-> $past(chk_launch)) // [R18]
    else $error("completion flag dropped without launch");

  active_code_a: assert property ($fell(q.command_complete_flag) |-> q.cmd == $past(q.param[0][15:8])) // [R1]
    else $error("active command code not taken");

  freeze_a: assert property (!clk_en |=> $stable(q.cnt) && $stable(q.command_complete_flag)) // [R18]
    else $error("state moved while clock enable low");

  param_lock_a: assert property ((q.ap_valid && q.ap_write && q.ap_addr == OFF_PARAM // [R18]
    && !q.command_complete_flag && clk_en) |=> $stable(q.param))
    else $error("parameter changed while running");

  verify_viol_a: assert property ((q.st == FCSQ_RUN && q.cmd == CMD_EV_ALL) // [R23]
    |=> $stable(q.protection_violation_flag))
    else $error("verify changed violation flag");

  verify_blk_viol_a: assert property ((q.st == FCSQ_RUN && q.cmd == CMD_EV_BLOCK) // [R23]
    |=> $stable(q.protection_violation_flag))
    else $error("block verify changed violation flag");

  mg_clear_a: assert property ($fell(q.command_complete_flag) |-> !q.mg_hi && !q.mg_lo) // [R22]
    else $error("margin status not cleared at launch");

  margin_hi_a: assert property ((q.st == FCSQ_RUN && q.cmd == CMD_EV_BLOCK // [R22]
    && verify_err && clk_en) |=> q.mg_hi)
    else $error("margin status not set");

  margin_lo_a: assert property ((q.st == FCSQ_RUN && q.cmd == CMD_EV_ALL // [R22]
    && verify_uncorr && clk_en) |=> q.mg_lo)
    else $error("lower margin status not set");

  // -------------------------------------------------------------------
  // Invalid read and register checks
  // -------------------------------------------------------------------
  inv_rd_cap_a: assert property ((flash_rd && !q.command_complete_flag && !q.sfd && !q.dfd && clk_en) // [R14]
    |=> q.sfd && q.dfd && q.ecc_addr == $past(flash_rd_addr))
    else $error("invalid read not captured");

  inv_rd_flag_a: assert property ((flash_rd && !q.command_complete_flag && clk_en) |=> rd_invalid) // [R13]
    else $error("invalid read not flagged");

  inv_rd_none_a: assert property (((!flash_rd || q.command_complete_flag) && clk_en) |=> !rd_invalid) // [R13]
    else $error("invalid read flagged without cause");

  ecc_hold_a: assert property ((q.sfd || q.dfd) |=> $stable(q.ecc_addr)) // [R14]
    else $error("captured address overwritten");

  ecc_keep_a: assert property ((q.sfd && clk_en // [R14]
    && !(q.ap_valid && q.ap_write && q.ap_addr == OFF_STATUS)) |=> q.sfd)
    else $error("single fault flag lost");

  ecc_zero_a: assert property ((hsel && hready && htrans == HTRANS_NONSEQ && !hwrite // [R15]
    && haddr[7:0] == OFF_ECC_DATA && clk_en) |=> hrdata == '0)
    else $error("ecc data field not zero");

  div_mark_a: assert property ((q.ap_valid && q.ap_write && q.ap_addr == OFF_CLKDIV // [R10]
    && clk_en) |=> q.div_set)
    else $error("divider write not marked");

  // -------------------------------------------------------------------
  // Coverage
  // -------------------------------------------------------------------
  run_cov: cover property (q.st == FCSQ_RUN ##1 q.command_complete_flag);
  err_cov: cover property ($rose(q.access_error_flag));
  inv_cov: cover property ($rose(q.sfd));
  viol_cov: cover property ($rose(q.protection_violation_flag));
  margin_cov: cover property (q.st == FCSQ_RUN ##1 $rose(q.mg_hi));
endmodule // fcsq_top
`default_nettype wire

// file: sim/fcsq_tb_top.sv
// Self-checking testbench for the flash command sequencer
`timescale 1ns/100ps
`default_nettype none
module fcsq_tb_top
  import fcsq_pkg::*;
;
  localparam int ALG_N = 24;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic flash_rd = 1'b0;
  logic [22:0] flash_rd_addr = 23'h0;
  logic verify_err = 1'b0;
  logic verify_uncorr = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, busy, rd_invalid;
  logic [7:0] active_cmd;
  logic [1:0] margin_level;
  logic [31:0] rd_q;
  logic pulse_seen;
  logic [7:0] cmds [4] = '{CMD_EV_SECTION, CMD_PROGRAM, CMD_ERASE_SECTOR, CMD_UNSECURE};
  logic [2:0] idxs [4] = '{3'h2, 3'h2, 3'h1, 3'h0};
  int fails = 0;
  int compares = 0;

  always #12.5 ref_clk = ~ref_clk;

  fcsq_top #(.ALG_LEN(ALG_N)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .flash_rd(flash_rd), .flash_rd_addr(flash_rd_addr),
    .verify_err(verify_err), .verify_uncorr(verify_uncorr), .busy(busy),
    .active_cmd(active_cmd), .margin_level(margin_level), .rd_invalid(rd_invalid));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("Counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd_q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd_q & mask, exp);
  endtask

  task automatic launch(input logic [7:0] cmd, input logic [6:0] blk, input logic [15:0] w1,
                        input logic [2:0] idx);
    bus(1'b1, OFF_PARIDX, 32'h0);
    bus(1'b1, OFF_PARAM, {16'h0, cmd, 1'b0, blk});
    bus(1'b1, OFF_PARIDX, 32'h1);
    bus(1'b1, OFF_PARAM, {16'h0, w1});
    bus(1'b1, OFF_PARIDX, {29'h0, idx});
    bus(1'b1, OFF_STATUS, 32'h80);
    repeat (3) @(posedge ref_clk);
  endtask

  // Run flag 2 means the busy level is not checked
  task automatic finish_cmd(input logic [1:0] ran, input logic [31:0] exp);
    int n;
    if (ran != 2'h2) check({31'h0, busy}, {31'h0, ran[0]});
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (busy !== 1'b0) begin
      fails++;
      complete_run();
    end
    rd(OFF_STATUS, 32'hb0, exp);
    bus(1'b1, OFF_STATUS, 32'h330);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(OFF_STATUS, 32'hffffffff, 32'h80);
    rd(8'h40, 32'hffffffff, 32'h0);
    launch(CMD_PROGRAM, DATA_BLOCK_ID, 16'h0, 3'h2);
    finish_cmd(2'h0, 32'ha0);
    rd(OFF_STATUS, 32'hb0, 32'h80);
    bus(1'b1, OFF_CLKDIV, 32'h13);
    launch(8'h05, DATA_BLOCK_ID, 16'h0, 3'h0);
    finish_cmd(2'h0, 32'ha0);
    $display("Test sequence errors done");
    launch(CMD_EV_ALL, 7'h0, 16'h0, IDX_ZERO);
    flash_rd <= 1'b1;
    flash_rd_addr <= 23'h102468;
    verify_err <= 1'b1;
    verify_uncorr <= 1'b1;
    pulse_seen = 1'b0;
    @(posedge ref_clk);
    flash_rd <= 1'b0;
    repeat (4) begin
      @(negedge ref_clk);
      if (rd_invalid === 1'b1) pulse_seen = 1'b1;
    end
    check({31'h0, pulse_seen}, 32'h1);
    rd(OFF_ECC_ADDR, 32'h7fffff, 32'h102468);
    rd(OFF_ECC_DATA, 32'hffffffff, 32'h0);
    rd(OFF_STATUS, 32'h380, 32'h300);
    verify_err <= 1'b0;
    verify_uncorr <= 1'b0;
    check({24'h0, active_cmd}, {24'h0, CMD_EV_ALL});
    finish_cmd(2'h1, 32'h80);
    rd(OFF_STATUS, 32'h3, 32'h3);
    launch(CMD_EV_ALL, 7'h0, 16'h0, 3'h1);
    finish_cmd(2'h0, 32'ha0);
    launch(CMD_EV_BLOCK, 7'h20, 16'h0, IDX_ZERO);
    finish_cmd(2'h0, 32'ha0);
    launch(CMD_EV_BLOCK, DATA_BLOCK_ID, 16'h0, IDX_ZERO);
    clk_en <= 1'b0;
    repeat (40) @(posedge ref_clk);
    check({31'h0, busy}, 32'h1);
    clk_en <= 1'b1;
    finish_cmd(2'h1, 32'h80);
    launch(CMD_EV_BLOCK, PGM_BLOCK_ID, 16'h0, IDX_ZERO);
    finish_cmd(2'h1, 32'h80);
    $display("Test verify done");
    launch(CMD_ERASE_BLOCK, DATA_BLOCK_ID, 16'h0, IDX_ZERO);
    finish_cmd(2'h0, 32'h90);
    bus(1'b1, OFF_PROT, 32'h8);
    launch(CMD_ERASE_BLOCK, DATA_BLOCK_ID, 16'h0, IDX_ZERO);
    finish_cmd(2'h1, 32'h80);
    bus(1'b1, OFF_PROT, 32'h7);
    launch(CMD_ERASE_ALL, 7'h0, 16'h0, IDX_ZERO);
    finish_cmd(2'h0, 32'h90);
    bus(1'b1, OFF_PROT, 32'hf);
    rd(OFF_PROT, 32'hf, 32'hf);
    launch(CMD_ERASE_ALL, 7'h0, 16'h0, IDX_ZERO);
    finish_cmd(2'h1, 32'h80);
    for (int i = 0; i < 4; i++) begin
      launch(cmds[i], DATA_BLOCK_ID, 16'h0, idxs[i]);
      finish_cmd(2'h1, 32'h80);
    end
    $display("Test erase and program done");
    launch(CMD_USER_MARGIN, DATA_BLOCK_ID, 16'h2, 3'h1);
    finish_cmd(2'h2, 32'h80);
    check({30'h0, margin_level}, 32'h2);
    launch(CMD_FIELD_MARGIN, DATA_BLOCK_ID, 16'h1, 3'h1);
    finish_cmd(2'h2, 32'ha0);
    bus(1'b1, OFF_MODE, 32'h1);
    launch(CMD_FIELD_MARGIN, DATA_BLOCK_ID, 16'h1, 3'h1);
    finish_cmd(2'h2, 32'h80);
    rd(OFF_MARGIN, 32'hf, 32'h6);
    $display("Test margins done");
    complete_run();
  end
endmodule // fcsq_tb_top
`default_nettype wire
